/* File: core/dbwu_consts.svh */
// Register indices, field positions and reset values of the debug watch unit
`ifndef DBWU_CONSTS_SVH
`define DBWU_CONSTS_SVH
`define DBWU_IDX_TYPE    8'h15
`define DBWU_IDX_DATA    8'h16
`define DBWU_IDX_RUN     8'h18
`define DBWU_IDX_SCR     8'h20
`define DBWU_IDX_IBA     8'h30
`define DBWU_IDX_IBC     8'h40
`define DBWU_IDX_DWA1    8'h50
`define DBWU_IDX_DWA2    8'h60
`define DBWU_IDX_DWC     8'h70
`define DBWU_IDX_RWM     8'h80
`define DBWU_IDX_RWV     8'h90
`define DBWU_IDX_RWC     8'h9C
`define DBWU_EN_BIT      0
`define DBWU_SENSE_BIT   1
`define DBWU_LOAD_BIT    2
`define DBWU_THR_LSB     16
`define DBWU_UNIT_LSB    16
`define DBWU_TNUM_LSB    8
`define DBWU_IBC_MASK    32'h00FF0003
`define DBWU_DWC_MASK    32'h00FF0007
`define DBWU_RWC_MASK    32'h00FF0003
`define DBWU_RUN_MASK    32'h000000FF
`define DBWU_TYPE_MASK   32'h0003FF07
`define DBWU_CTRL_RST    32'h00000000
`define DBWU_WORD_RST    32'h00000000
`endif

/* File: core/dbwu_pkg.sv */
// Types shared by the debug watch unit modules
package dbwu_pkg;
  typedef enum logic [2:0] {
    DBWU_CAUSE_NONE = 3'h0,
    DBWU_CAUSE_HOST = 3'h1,
    DBWU_CAUSE_CALL = 3'h2,
    DBWU_CAUSE_IBRK = 3'h3,
    DBWU_CAUSE_DWAT = 3'h4,
    DBWU_CAUSE_RWAT = 3'h5
  } dbwu_cause_e;
  typedef enum logic [0:0] {
    DBWU_ST_RUN   = 1'b0,
    DBWU_ST_DEBUG = 1'b1
  } dbwu_state_e;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [31:0] wdata;
  } dbwu_bus_s;
  typedef struct packed {
    logic        valid;
    logic [2:0]  thread;
    logic [31:0] pc;
  } dbwu_fetch_s;
  typedef struct packed {
    logic        valid;
    logic [2:0]  thread;
    logic        is_load;
    logic [31:0] addr;
  } dbwu_mem_s;
  typedef struct packed {
    logic        valid;
    logic [2:0]  thread;
    logic [31:0] id;
  } dbwu_res_s;
endpackage

/* File: core/dbwu_match.sv */
// Compare logic of one breakpoint, one data and one resource watchpoint
`include "dbwu_consts.svh"
module dbwu_match import dbwu_pkg::*; (
  input  wire logic [31:0] ib_ctrl,
  input  wire logic [31:0] ib_addr,
  input  wire logic [31:0] dw_ctrl,
  input  wire logic [31:0] dw_addr1,
  input  wire logic [31:0] dw_addr2,
  input  wire logic [31:0] rw_ctrl,
  input  wire logic [31:0] rw_mask,
  input  wire logic [31:0] rw_value,
  input  wire dbwu_fetch_s fetch,
  input  wire dbwu_mem_s   mem,
  input  wire dbwu_res_s   res,
  output logic             ib_hit,
  output logic             dw_hit,
  output logic             rw_hit
);
  logic dw_a;
  logic dw_b;
  logic dw_kind;
  logic rw_a;

  always_comb begin
    ib_hit = fetch.valid && ib_ctrl[`DBWU_EN_BIT]
          && ib_ctrl[`DBWU_THR_LSB + fetch.thread]
          && ((fetch.pc != ib_addr) == ib_ctrl[`DBWU_SENSE_BIT]);
  end

  always_comb begin
    dw_a    = mem.addr == dw_addr1;
    dw_b    = mem.addr == dw_addr2;
    dw_kind = mem.is_load == dw_ctrl[`DBWU_LOAD_BIT];
    dw_hit  = mem.valid && dw_ctrl[`DBWU_EN_BIT] && dw_kind
           && dw_ctrl[`DBWU_THR_LSB + mem.thread]
           && (dw_ctrl[`DBWU_SENSE_BIT] ? (dw_a || dw_b) : (dw_a && dw_b));
  end

  always_comb begin
    rw_a   = (res.id & rw_mask) == (rw_value & rw_mask);
    rw_hit = res.valid && rw_ctrl[`DBWU_EN_BIT]
          && rw_ctrl[`DBWU_THR_LSB + res.thread]
          && (rw_ctrl[`DBWU_SENSE_BIT] ? !rw_a : rw_a);
  end
endmodule

/* File: core/dbwu_top.sv */
// Debug breakpoint and watchpoint unit of one processor tile
// Function
// - data watchpoint hit loads event data with the effective address
// - resource watchpoint hit loads event data with the resource identifier
// - eight-bit run-stop mask stops flagged cores outside debug mode
// - after debug return, flagged cores stay stopped for single stepping
// - eight scratch words shared with the tile configuration path
// - enabled instruction breakpoint match by permitted core raises debug interrupt
// - four instruction breakpoints, each with address and control register
// - control bits 23:16 enable each unit per thread
// - instruction control bit 1 selects break on equal or unequal
// - control bit 0 enables a unit; control bits reset to zero
// - first compare address per data watchpoint
// - second compare address per data watchpoint
// - control register per data watchpoint
// - data control bit 2 makes the watchpoint trigger on loads
// - data control bit 1 combines conditions by AND or OR
// - mask word per resource watchpoint
// - compare value per resource watchpoint
// - control register per resource watchpoint
// - resource control bit 1 picks condition A or B
// - record cause code 1 to 5 on each debug interrupt
// - record lowest triggering unit number in two bits
// - record triggering core number in three bits
`include "dbwu_consts.svh"
module dbwu_top import dbwu_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire dbwu_bus_s   bus,
  output logic [31:0]      bus_rdata,
  input  wire dbwu_fetch_s fetch,
  input  wire dbwu_mem_s   mem,
  input  wire dbwu_res_s   res,
  input  wire logic        host_dbg_req,
  input  wire logic        call_req,
  input  wire logic [2:0]  call_thread,
  input  wire logic        dbg_return,
  input  wire logic        cfg_scr_wr,
  input  wire logic [2:0]  cfg_scr_idx,
  input  wire logic [31:0] cfg_scr_wdata,
  output logic [31:0]      cfg_scr_rdata,
  output logic             debug_irq,
  output logic             in_debug,
  output logic [7:0]       core_stop
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ib_addr_r  [4];
  logic [31:0] ib_ctrl_r  [4];
  logic [31:0] dw_addr1_r [4];
  logic [31:0] dw_addr2_r [4];
  logic [31:0] dw_ctrl_r  [4];
  logic [31:0] rw_mask_r  [4];
  logic [31:0] rw_value_r [4];
  logic [31:0] rw_ctrl_r  [4];
  logic [31:0] scratch    [8];
  logic [31:0] run_mask_r;
  logic [31:0] type_r;
  logic [31:0] data_r;
  logic        irq_r;
  dbwu_state_e state_r;
  dbwu_state_e state_nxt;
  logic [3:0]  ib_hit;
  logic [3:0]  dw_hit;
  logic [3:0]  rw_hit;
  logic [7:0]  idx;
  logic        fire;
  dbwu_cause_e cause;
  logic [1:0]  unit;
  logic [2:0]  thread;
  logic [31:0] ev_data;
  logic [31:0] rd_mux;

  function automatic logic [1:0] lowest(input logic [3:0] hits);
    logic [1:0] n;
    n = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (hits[i]) begin
        n = 2'(i);
      end
    end
    return n;
  endfunction

  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    return a[7:2] == base[7:2];
  endfunction

  assign idx = bus.addr[9:2];

  ////////////////////////////////////////////////////////////////////////////
  // Per-unit comparators
  for (genvar g = 0; g < 4; g++) begin : g_unit
    dbwu_match u_match (
      .ib_ctrl  (ib_ctrl_r[g]),
      .ib_addr  (ib_addr_r[g]),
      .dw_ctrl  (dw_ctrl_r[g]),
      .dw_addr1 (dw_addr1_r[g]),
      .dw_addr2 (dw_addr2_r[g]),
      .rw_ctrl  (rw_ctrl_r[g]),
      .rw_mask  (rw_mask_r[g]),
      .rw_value (rw_value_r[g]),
      .fetch    (fetch),
      .mem      (mem),
      .res      (res),
      .ib_hit   (ib_hit[g]),
      .dw_hit   (dw_hit[g]),
      .rw_hit   (rw_hit[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event arbitration: host, call, breakpoint, data, resource
  always_comb begin
    cause   = DBWU_CAUSE_NONE;
    unit    = 2'h0;
    thread  = 3'h0;
    ev_data = data_r;
    if (host_dbg_req) begin
      cause = DBWU_CAUSE_HOST;
    end else if (call_req) begin
      cause  = DBWU_CAUSE_CALL;
      thread = call_thread;
    end else if (|ib_hit) begin
      cause  = DBWU_CAUSE_IBRK;
      unit   = lowest(ib_hit);
      thread = fetch.thread;
    end else if (|dw_hit) begin
      cause   = DBWU_CAUSE_DWAT;
      unit    = lowest(dw_hit);
      thread  = mem.thread;
      ev_data = mem.addr;
    end else if (|rw_hit) begin
      cause   = DBWU_CAUSE_RWAT;
      unit    = lowest(rw_hit);
      thread  = res.thread;
      ev_data = res.id;
    end
    fire = (state_r == DBWU_ST_RUN) && (cause != DBWU_CAUSE_NONE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debug mode state
  always_comb begin
    case (state_r)
      DBWU_ST_RUN:   state_nxt = fire ? DBWU_ST_DEBUG : DBWU_ST_RUN;
      DBWU_ST_DEBUG: state_nxt = dbg_return ? DBWU_ST_RUN : DBWU_ST_DEBUG;
      default:       state_nxt = DBWU_ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= DBWU_ST_RUN;
      irq_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      irq_r   <= fire;
    end
  end

  assign debug_irq = irq_r;
  assign in_debug  = state_r == DBWU_ST_DEBUG;
  assign core_stop = in_debug ? 8'h00 : run_mask_r[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Event record; hardware capture wins over a software write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      type_r <= `DBWU_WORD_RST;
      data_r <= `DBWU_WORD_RST;
    end else if (fire) begin
      type_r <= {14'h0000, unit, 5'h00, thread, 5'h00, cause};
      data_r <= ev_data;
    end else if (bus.wr) begin
      if (idx == `DBWU_IDX_TYPE) begin
        type_r <= bus.wdata & `DBWU_TYPE_MASK;
      end
      if (idx == `DBWU_IDX_DATA) begin
        data_r <= bus.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run-stop mask
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_mask_r <= `DBWU_CTRL_RST;
    end else if (bus.wr && idx == `DBWU_IDX_RUN) begin
      run_mask_r <= bus.wdata & `DBWU_RUN_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scratch words, one array for both paths; the register bus wins a clash
  always_ff @(posedge sys_clk) begin
    if (bus.wr && in_bank(idx, `DBWU_IDX_SCR) && idx[2] == 1'b0) begin
      scratch[idx[2:0]] <= bus.wdata;
    end else if (bus.wr && idx[7:3] == 5'h04) begin
      scratch[idx[2:0]] <= bus.wdata;
    end else if (cfg_scr_wr) begin
      scratch[cfg_scr_idx] <= cfg_scr_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    cfg_scr_rdata <= scratch[cfg_scr_idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Breakpoint and watchpoint registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        ib_addr_r[i]  <= `DBWU_WORD_RST;
        ib_ctrl_r[i]  <= `DBWU_CTRL_RST;
        dw_addr1_r[i] <= `DBWU_WORD_RST;
        dw_addr2_r[i] <= `DBWU_WORD_RST;
        dw_ctrl_r[i]  <= `DBWU_CTRL_RST;
        rw_mask_r[i]  <= `DBWU_WORD_RST;
        rw_value_r[i] <= `DBWU_WORD_RST;
        rw_ctrl_r[i]  <= `DBWU_CTRL_RST;
      end
    end else if (bus.wr) begin
      if (in_bank(idx, `DBWU_IDX_IBA)) begin
        ib_addr_r[idx[1:0]] <= bus.wdata;
      end
      if (in_bank(idx, `DBWU_IDX_IBC)) begin
        ib_ctrl_r[idx[1:0]] <= bus.wdata & `DBWU_IBC_MASK;
      end
      if (in_bank(idx, `DBWU_IDX_DWA1)) begin
        dw_addr1_r[idx[1:0]] <= bus.wdata;
      end
      if (in_bank(idx, `DBWU_IDX_DWA2)) begin
        dw_addr2_r[idx[1:0]] <= bus.wdata;
      end
      if (in_bank(idx, `DBWU_IDX_DWC)) begin
        dw_ctrl_r[idx[1:0]] <= bus.wdata & `DBWU_DWC_MASK;
      end
      if (in_bank(idx, `DBWU_IDX_RWM)) begin
        rw_mask_r[idx[1:0]] <= bus.wdata;
      end
      if (in_bank(idx, `DBWU_IDX_RWV)) begin
        rw_value_r[idx[1:0]] <= bus.wdata;
      end
      if (in_bank(idx, `DBWU_IDX_RWC)) begin
        rw_ctrl_r[idx[1:0]] <= bus.wdata & `DBWU_RWC_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped indices read zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (idx == `DBWU_IDX_TYPE) begin
      rd_mux = type_r;
    end else if (idx == `DBWU_IDX_DATA) begin
      rd_mux = data_r;
    end else if (idx == `DBWU_IDX_RUN) begin
      rd_mux = run_mask_r;
    end else if (idx[7:3] == 5'h04) begin
      rd_mux = scratch[idx[2:0]];
    end else if (in_bank(idx, `DBWU_IDX_IBA)) begin
      rd_mux = ib_addr_r[idx[1:0]];
    end else if (in_bank(idx, `DBWU_IDX_IBC)) begin
      rd_mux = ib_ctrl_r[idx[1:0]];
    end else if (in_bank(idx, `DBWU_IDX_DWA1)) begin
      rd_mux = dw_addr1_r[idx[1:0]];
    end else if (in_bank(idx, `DBWU_IDX_DWA2)) begin
      rd_mux = dw_addr2_r[idx[1:0]];
    end else if (in_bank(idx, `DBWU_IDX_DWC)) begin
      rd_mux = dw_ctrl_r[idx[1:0]];
    end else if (in_bank(idx, `DBWU_IDX_RWM)) begin
      rd_mux = rw_mask_r[idx[1:0]];
    end else if (in_bank(idx, `DBWU_IDX_RWV)) begin
      rd_mux = rw_value_r[idx[1:0]];
    end else if (in_bank(idx, `DBWU_IDX_RWC)) begin
      rd_mux = rw_ctrl_r[idx[1:0]];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_rdata <= 32'h00000000;
    end else begin
      bus_rdata <= bus.rd ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic quiet;
  assign quiet = !host_dbg_req && !call_req;

  property p_ib_cause;
    (state_r == DBWU_ST_RUN && quiet && |ib_hit)
      |=> (debug_irq && type_r[2:0] == 3'h3 && in_debug);
  endproperty
  a_ib_cause: assert property (p_ib_cause) else $error("breakpoint did not raise cause 3");

  property p_dw_data;
    (state_r == DBWU_ST_RUN && quiet && !(|ib_hit) && |dw_hit)
      |=> (data_r == $past(mem.addr) && type_r[2:0] == 3'h4);
  endproperty
  a_dw_data: assert property (p_dw_data) else $error("data watch did not capture address");

  property p_rw_data;
    (fire && cause == DBWU_CAUSE_RWAT) |=> (data_r == $past(res.id) && type_r[2:0] == 3'h5);
  endproperty
  a_rw_data: assert property (p_rw_data) else $error("resource watch did not capture id");

  property p_run_mask;
    (bus.wr && idx == `DBWU_IDX_RUN && !in_debug && !fire)
      |=> (core_stop == $past(bus.wdata[7:0]));
  endproperty
  a_run_mask: assert property (p_run_mask) else $error("run-stop mask not applied");

  property p_return_stop;
    $fell(in_debug) |-> (core_stop == run_mask_r[7:0] && !debug_irq);
  endproperty
  a_return_stop: assert property (p_return_stop) else $error("masked cores run after return");

  property p_scratch_share;
    (bus.wr && idx[7:3] == 5'h04) ##1 (cfg_scr_idx == $past(idx[2:0]) && !cfg_scr_wr)
      |=> (cfg_scr_rdata == $past(bus.wdata, 2));
  endproperty
  a_scratch_share: assert property (p_scratch_share) else $error("scratch not shared");

  property p_lowest_unit;
    (fire && cause == DBWU_CAUSE_IBRK && ib_hit[0])
      |=> (type_r[17:16] == 2'h0 && type_r[15:8] == {5'h00, $past(fetch.thread)});
  endproperty
  a_lowest_unit: assert property (p_lowest_unit) else $error("wrong unit or core recorded");

  property p_ib_unequal;
    (fetch.valid && fetch.thread == 3'h0 && ib_ctrl_r[0] == 32'h00010003 && fetch.pc != ib_addr_r[0])
      |-> ib_hit[0];
  endproperty
  a_ib_unequal: assert property (p_ib_unequal) else $error("unequal sense missed");

  property p_dw_or;
    (mem.valid && !mem.is_load && mem.thread == 3'h1 && dw_ctrl_r[1] == 32'h00020003 && mem.addr == dw_addr2_r[1])
      |-> dw_hit[1];
  endproperty
  a_dw_or: assert property (p_dw_or) else $error("OR store condition missed");

  property p_disabled;
    (ib_ctrl_r[0][0] == 1'b0) |-> !ib_hit[0];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled unit fired");

  c_ib_fire: cover property (fire && cause == DBWU_CAUSE_IBRK);
  c_dw_fire: cover property (fire && cause == DBWU_CAUSE_DWAT);
  c_rw_fire: cover property (fire && cause == DBWU_CAUSE_RWAT);
  c_step: cover property (in_debug ##1 !in_debug && core_stop != 8'h00);
endmodule

/* File: bench/dbwu_core_model.sv */
// Behavioural model of the logical cores and the debugger facing the watch unit
module dbwu_core_model import dbwu_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  core_stop,
  output dbwu_fetch_s      fetch,
  output dbwu_mem_s        mem,
  output dbwu_res_s        res,
  output logic             host_dbg_req,
  output logic             call_req,
  output logic [2:0]       call_thread,
  output logic             dbg_return
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fetch = '0;
    mem = '0;
    res = '0;
    host_dbg_req = 1'h0;
    call_req = 1'h0;
    call_thread = 3'h0;
    dbg_return = 1'h0;
  end
  ////////////////////////////////////////////////////////////////
  // One-cycle issues; released fields show inverted junk, not the old value
  task automatic do_fetch(input logic [2:0] t, input logic [31:0] pc);
    @(posedge sys_clk);
    // A stopped core issues no fetch
    if (!core_stop[t]) begin
      fetch <= '{1'h1, t, pc};
    end
    @(posedge sys_clk);
    fetch <= '{1'h0, ~t, ~pc};
  endtask
  task automatic do_mem(input logic [2:0] t, input logic ld, input logic [31:0] a);
    @(posedge sys_clk);
    mem <= '{1'h1, t, ld, a};
    @(posedge sys_clk);
    mem <= '{1'h0, ~t, ~ld, ~a};
  endtask
  task automatic do_res(input logic [2:0] t, input logic [31:0] id);
    @(posedge sys_clk);
    res <= '{1'h1, t, id};
    @(posedge sys_clk);
    res <= '{1'h0, ~t, ~id};
  endtask
  task automatic ctl(input logic h, input logic c, input logic r, input logic [2:0] t);
    @(posedge sys_clk);
    host_dbg_req <= h;
    call_req <= c;
    call_thread <= t;
    dbg_return <= r;
    @(posedge sys_clk);
    host_dbg_req <= 1'h0;
    call_req <= 1'h0;
    call_thread <= ~t;
    dbg_return <= 1'h0;
  endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking testbench of the debug watch unit
module testbench import dbwu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        sys_rst;
  dbwu_bus_s   bus;
  logic [31:0] bus_rdata;
  dbwu_fetch_s fetch;
  dbwu_mem_s   mem;
  dbwu_res_s   res;
  logic        host_dbg_req;
  logic        call_req;
  logic [2:0]  call_thread;
  logic        dbg_return;
  logic        cfg_scr_wr;
  logic [2:0]  cfg_scr_idx;
  logic [31:0] cfg_scr_wdata;
  logic [31:0] cfg_scr_rdata;
  logic        debug_irq;
  logic        in_debug;
  logic [7:0]  core_stop;
  int          failures;
  int          num_checks;
  logic [7:0]  bases [5] = '{8'h30, 8'h50, 8'h60, 8'h80, 8'h90};
  logic [7:0]  cbase [3] = '{8'h40, 8'h70, 8'h9C};
  logic [31:0] cmask [3] = '{32'h00FF0003, 32'h00FF0007, 32'h00FF0003};
  dbwu_top dbwu_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .bus_rdata(bus_rdata),
    .fetch(fetch), .mem(mem), .res(res), .host_dbg_req(host_dbg_req), .call_req(call_req),
    .call_thread(call_thread), .dbg_return(dbg_return), .cfg_scr_wr(cfg_scr_wr),
    .cfg_scr_idx(cfg_scr_idx), .cfg_scr_wdata(cfg_scr_wdata), .cfg_scr_rdata(cfg_scr_rdata),
    .debug_irq(debug_irq), .in_debug(in_debug), .core_stop(core_stop));
  dbwu_core_model dbwu_core_model_inst (.sys_clk(sys_clk), .core_stop(core_stop), .fetch(fetch),
    .mem(mem), .res(res), .host_dbg_req(host_dbg_req), .call_req(call_req),
    .call_thread(call_thread), .dbg_return(dbg_return));
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{1'h1, 1'h0, {idx, 2'h0}, d};
    @(posedge sys_clk);
    bus <= '{1'h0, 1'h0, ~{idx, 2'h0}, ~d};
  endtask
  task automatic chk_rd(input logic [7:0] idx, input logic [31:0] exp);
    @(posedge sys_clk);
    bus <= '{1'h0, 1'h1, {idx, 2'h0}, 32'h0};
    @(posedge sys_clk);
    bus <= '{1'h0, 1'h0, ~{idx, 2'h0}, 32'h0};
    #1 chk(bus_rdata, exp);
  endtask
  // Checks the pulse; on a hit reads the type record, plus the data record for causes 4 and 5, and leaves debug mode
  task automatic ev(input logic fire, input logic [31:0] ty, input logic [31:0] dat);
    #1 chk({31'h0, debug_irq}, {31'h0, fire});
    if (fire) begin
      chk({31'h0, in_debug}, 32'h1);
      chk_rd(8'h15, ty);
      if (ty[2:0] >= 3'h4) begin
        chk_rd(8'h16, dat);
      end
      dbwu_core_model_inst.ctl(1'h0, 1'h0, 1'h1, 3'h0);
      #1 chk({31'h0, in_debug}, 32'h0);
    end
  endtask
  task automatic dw(input logic [31:0] c, input logic ld, input logic [31:0] a, input logic f);
    wr(8'h71, c);
    dbwu_core_model_inst.do_mem(3'h1, ld, a);
    ev(f, 32'h00010104, a);
  endtask
  task automatic rw(input logic [31:0] c, input logic [31:0] id, input logic f);
    wr(8'h9F, c);
    dbwu_core_model_inst.do_res(3'h4, id);
    ev(f, 32'h00030405, id);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    failures++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'h1;
    bus = '0;
    cfg_scr_wr = 1'h0;
    cfg_scr_idx = 3'h0;
    cfg_scr_wdata = 32'h0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'h0;
    // Reset values, unmapped index reads zero
    foreach (cbase[i]) chk_rd(cbase[i], 32'h0);
    chk_rd(8'h18, 32'h0);
    chk_rd(8'h17, 32'h0);
    chk({24'h0, core_stop}, 32'h0);
    // Address and value words per unit, then masked control words
    for (int u = 0; u < 4; u++) begin
      foreach (bases[i]) wr(bases[i] + u[7:0], {bases[i], 8'h5A, 8'hC3, u[7:0]});
      foreach (bases[i]) chk_rd(bases[i] + u[7:0], {bases[i], 8'h5A, 8'hC3, u[7:0]});
      foreach (cbase[i]) wr(cbase[i] + u[7:0], 32'hFFFFFFFF);
      foreach (cbase[i]) chk_rd(cbase[i] + u[7:0], cmask[i]);
      foreach (cbase[i]) wr(cbase[i] + u[7:0], 32'h0);
    end
    wr(8'h17, 32'h12345678);
    chk_rd(8'h17, 32'h0);
    wr(8'h18, 32'hFFFFFFFF);
    chk_rd(8'h18, 32'h000000FF);
    wr(8'h18, 32'h0);
    // Scratch words seen from both paths
    cfg_scr_idx <= 3'h1;
    wr(8'h21, 32'hCAFE0021);
    @(posedge sys_clk);
    @(posedge sys_clk);
    #1 chk(cfg_scr_rdata, 32'hCAFE0021);
    @(posedge sys_clk);
    cfg_scr_wr <= 1'h1;
    cfg_scr_idx <= 3'h5;
    cfg_scr_wdata <= 32'hBEEF0025;
    @(posedge sys_clk);
    cfg_scr_wr <= 1'h0;
    chk_rd(8'h25, 32'hBEEF0025);
    // Instruction breakpoints
    wr(8'h31, 32'h00001000);
    wr(8'h41, 32'h00040001);
    dbwu_core_model_inst.do_fetch(3'h3, 32'h00001000);
    ev(1'h0, 32'h0, 32'h0);
    dbwu_core_model_inst.do_fetch(3'h2, 32'h00001004);
    ev(1'h0, 32'h0, 32'h0);
    dbwu_core_model_inst.do_fetch(3'h2, 32'h00001000);
    ev(1'h1, 32'h00010203, 32'h0);
    wr(8'h41, 32'h0);
    wr(8'h30, 32'h00002000);
    wr(8'h40, 32'h00010002);
    dbwu_core_model_inst.do_fetch(3'h0, 32'h00004000);
    ev(1'h0, 32'h0, 32'h0);
    wr(8'h40, 32'h00010003);
    wr(8'h32, 32'h00003000);
    wr(8'h42, 32'h00010003);
    dbwu_core_model_inst.do_fetch(3'h0, 32'h00002000);
    ev(1'h1, 32'h00020003, 32'h0);
    dbwu_core_model_inst.do_fetch(3'h0, 32'h00004000);
    ev(1'h1, 32'h00000003, 32'h0);
    wr(8'h40, 32'h0);
    wr(8'h42, 32'h0);
    // Data watchpoint 1, thread 1
    wr(8'h51, 32'h00000100);
    wr(8'h61, 32'h00000200);
    dw(32'h00020003, 1'h0, 32'h00000200, 1'h1);
    dw(32'h00020003, 1'h1, 32'h00000100, 1'h0);
    dw(32'h00020001, 1'h0, 32'h00000100, 1'h0);
    dw(32'h00020007, 1'h1, 32'h00000100, 1'h1);
    dw(32'h00020007, 1'h0, 32'h00000100, 1'h0);
    dw(32'h00040003, 1'h0, 32'h00000200, 1'h0);
    wr(8'h61, 32'h00000100);
    dw(32'h00020001, 1'h0, 32'h00000100, 1'h1);
    wr(8'h71, 32'h0);
    // Resource watchpoint 3, thread 4
    wr(8'h83, 32'h0000FF00);
    wr(8'h93, 32'h00001200);
    rw(32'h00100001, 32'h00AB12CD, 1'h1);
    rw(32'h00100001, 32'h00AB34CD, 1'h0);
    rw(32'h00100003, 32'h00001200, 1'h0);
    rw(32'h00100003, 32'h00003400, 1'h1);
    wr(8'h9F, 32'h0);
    // Host and call causes, priority, refusal while in debug
    dbwu_core_model_inst.ctl(1'h1, 1'h0, 1'h0, 3'h0);
    ev(1'h1, 32'h00000001, 32'h0);
    dbwu_core_model_inst.ctl(1'h0, 1'h1, 1'h0, 3'h6);
    ev(1'h1, 32'h00000602, 32'h0);
    dbwu_core_model_inst.ctl(1'h1, 1'h1, 1'h0, 3'h6);
    ev(1'h1, 32'h00000001, 32'h0);
    dbwu_core_model_inst.ctl(1'h1, 1'h0, 1'h0, 3'h0);
    dbwu_core_model_inst.ctl(1'h0, 1'h1, 1'h0, 3'h5);
    ev(1'h0, 32'h0, 32'h0);
    chk_rd(8'h15, 32'h00000001);
    dbwu_core_model_inst.ctl(1'h0, 1'h0, 1'h1, 3'h0);
    // Run-stop mask outside and inside debug mode
    wr(8'h18, 32'h00000005);
    #1 chk({24'h0, core_stop}, 32'h00000005);
    dbwu_core_model_inst.ctl(1'h1, 1'h0, 1'h0, 3'h0);
    #1 chk({24'h0, core_stop}, 32'h0);
    dbwu_core_model_inst.ctl(1'h0, 1'h0, 1'h1, 3'h0);
    #1 chk({24'h0, core_stop}, 32'h00000005);
    wr(8'h18, 32'h0);
    tally_and_finish();
  end
endmodule
